// [hw/psb_pkg.sv]
package psb_pkg;
    localparam int          NUM_SLOTS      = 4;
    localparam int          ADDR_W         = 8;
    // byte addresses of the register words
    localparam logic [7:0]  ADDR_STATUS    = 8'h00;
    localparam logic [7:0]  ADDR_CONTROL   = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h0C;
    localparam logic [7:0]  ADDR_IN_BASE   = 8'h10;
    localparam logic [7:0]  ADDR_OUT_BASE  = 8'h20;
    // status field positions
    localparam int          BIT_ALL_IN_FULL  = 15;
    localparam int          BIT_IN_OVF       = 14;
    localparam int          BIT_IN_FULL_LO   = 8;
    localparam int          BIT_ALL_OUT_EMPTY = 7;
    localparam int          BIT_OUT_UNF      = 6;
    localparam int          BIT_OUT_EMPTY_LO = 0;
    // control field positions
    localparam int          BIT_SLAVE_EN     = 0;
    // interrupt event positions
    localparam int          IRQ_IN_OVF       = 0;
    localparam int          IRQ_OUT_UNF      = 1;
    localparam int          IRQ_IN_WRITTEN   = 2;
    localparam int          IRQ_OUT_TAKEN    = 3;
    localparam int          NUM_IRQ          = 4;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    localparam logic [3:0]  SLOTS_NONE       = 4'h0;
    localparam logic [3:0]  SLOTS_ALL        = 4'hF;
endpackage

// [hw/psb_slots.sv]
`timescale 1ns/1ps
// slot flag bookkeeping for the buffered slave mode
module psb_slots (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // host side events, one-cycle pulses
    input  wire logic       host_wr,
    input  wire logic [1:0] host_wr_slot,
    input  wire logic       host_rd,
    input  wire logic [1:0] host_rd_slot,
    // software side events, one-cycle pulses
    input  wire logic       sw_in_rd,
    input  wire logic [1:0] sw_in_slot,
    input  wire logic       sw_out_wr,
    input  wire logic [1:0] sw_out_slot,
    input  wire logic       clr_ovf,
    input  wire logic       clr_unf,
    // flags
    output logic [3:0]      in_full,
    output logic [3:0]      out_empty,
    output logic            in_ovf,
    output logic            out_unf,
    output logic            ovf_evt,
    output logic            unf_evt
);
    logic [3:0] in_full_r, in_full_nxt, out_empty_r, out_empty_nxt;
    logic       ovf_r, ovf_nxt, unf_r, unf_nxt;

    always_comb begin
        in_full_nxt   = in_full_r;
        out_empty_nxt = out_empty_r;
        ovf_evt       = host_wr && in_full_r[host_wr_slot];
        unf_evt       = host_rd && out_empty_r[host_rd_slot];
        if (sw_in_rd) begin
            in_full_nxt[sw_in_slot] = 1'b0;
        end
        if (host_wr) begin
            in_full_nxt[host_wr_slot] = 1'b1;
        end
        if (host_rd) begin
            out_empty_nxt[host_rd_slot] = 1'b1;
        end
        if (sw_out_wr) begin
            out_empty_nxt[sw_out_slot] = 1'b0;
        end
        // set wins over a clear in the same cycle
        ovf_nxt = (ovf_r && !clr_ovf) || ovf_evt;
        unf_nxt = (unf_r && !clr_unf) || unf_evt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_full_r   <= psb_pkg::SLOTS_NONE;
            out_empty_r <= psb_pkg::SLOTS_ALL;
            ovf_r       <= 1'b0;
            unf_r       <= 1'b0;
        end else begin
            in_full_r   <= in_full_nxt;
            out_empty_r <= out_empty_nxt;
            ovf_r       <= ovf_nxt;
            unf_r       <= unf_nxt;
        end
    end

    assign in_full   = in_full_r;
    assign out_empty = out_empty_r;
    assign in_ovf    = ovf_r;
    assign out_unf   = unf_r;
endmodule

// [hw/psb_top.sv]
`timescale 1ns/1ps
// buffered slave parallel port: byte slots, status flags, axi4-lite registers
module psb_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // axi4-lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // axi4-lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // external host strobes, one-cycle pulses
    input  wire logic        host_wr,
    input  wire logic [1:0]  host_wr_slot,
    input  wire logic [7:0]  host_wr_data,
    input  wire logic        host_rd,
    input  wire logic [1:0]  host_rd_slot,
    output logic [7:0]       host_rd_data,
    // interrupt
    output logic             irq
);
    logic [7:0]  in_data_r [4];
    logic [7:0]  in_data_nxt [4];
    logic [7:0]  out_data_r [4];
    logic [7:0]  out_data_nxt [4];
    logic [7:0]  host_rd_data_r, host_rd_data_nxt;
    logic        slave_en_r, slave_en_nxt;
    logic [3:0]  irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
    logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [7:0]  awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0]  wstrb_r, wstrb_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic        wr_go, rd_go, h_wr, h_rd;
    logic        sw_in_rd, sw_out_wr, clr_ovf, clr_unf;
    logic [1:0]  sw_in_slot, sw_out_slot;
    logic [3:0]  in_full, out_empty;
    logic        in_ovf, out_unf, ovf_evt, unf_evt;
    logic [31:0] status_word;

    // slot index when addr hits a four-word slot window
    function automatic logic slot_hit(input logic [7:0] a, input logic [7:0] base);
        slot_hit = (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [1:0] slot_of(input logic [7:0] a);
        slot_of = a[3:2];
    endfunction

    // host strobes are ignored outside slave mode
    assign h_wr = host_wr && slave_en_r;
    assign h_rd = host_rd && slave_en_r;

    assign wr_go = aw_got_r && w_got_r && !bvalid_r;
    assign rd_go = s_axi_arvalid && !rvalid_r;
    assign sw_in_rd    = rd_go && slot_hit(s_axi_araddr, psb_pkg::ADDR_IN_BASE);
    assign sw_in_slot  = slot_of(s_axi_araddr);
    assign sw_out_wr   = wr_go && slot_hit(awaddr_r, psb_pkg::ADDR_OUT_BASE)
                         && wstrb_r[0];
    assign sw_out_slot = slot_of(awaddr_r);
    assign clr_ovf = wr_go && (awaddr_r == psb_pkg::ADDR_STATUS) && wstrb_r[1]
                     && wdata_r[psb_pkg::BIT_IN_OVF];
    assign clr_unf = wr_go && (awaddr_r == psb_pkg::ADDR_STATUS) && wstrb_r[0]
                     && wdata_r[psb_pkg::BIT_OUT_UNF];

    psb_slots u_slots (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .host_wr      (h_wr),
        .host_wr_slot (host_wr_slot),
        .host_rd      (h_rd),
        .host_rd_slot (host_rd_slot),
        .sw_in_rd     (sw_in_rd),
        .sw_in_slot   (sw_in_slot),
        .sw_out_wr    (sw_out_wr),
        .sw_out_slot  (sw_out_slot),
        .clr_ovf      (clr_ovf),
        .clr_unf      (clr_unf),
        .in_full      (in_full),
        .out_empty    (out_empty),
        .in_ovf       (in_ovf),
        .out_unf      (out_unf),
        .ovf_evt      (ovf_evt),
        .unf_evt      (unf_evt)
    );

    // unimplemented fields stay zero; whole word zero outside slave mode
    always_comb begin
        status_word = 32'h0000_0000;
        if (slave_en_r) begin
            status_word[psb_pkg::BIT_ALL_IN_FULL] = &in_full;
            status_word[psb_pkg::BIT_IN_OVF] = in_ovf;
            status_word[psb_pkg::BIT_IN_FULL_LO +: 4] = in_full;
            status_word[psb_pkg::BIT_ALL_OUT_EMPTY] = &out_empty;
            status_word[psb_pkg::BIT_OUT_UNF] = out_unf;
            status_word[psb_pkg::BIT_OUT_EMPTY_LO +: 4] = out_empty;
        end
    end

    // data slots and host read path
    always_comb begin
        in_data_nxt      = in_data_r;
        out_data_nxt     = out_data_r;
        host_rd_data_nxt = host_rd_data_r;
        // overwrite on overflow: the newer byte is kept, the flag reports the loss
        if (h_wr) begin
            in_data_nxt[host_wr_slot] = host_wr_data;
        end
        if (sw_out_wr) begin
            out_data_nxt[sw_out_slot] = wdata_r[7:0];
        end
        if (h_rd) begin
            host_rd_data_nxt = out_data_r[host_rd_slot];
        end
    end

    // interrupt status, mask, control and the bus channels
    always_comb begin
        logic [3:0] evt;
        evt = 4'h0;
        evt[psb_pkg::IRQ_IN_OVF]     = ovf_evt;
        evt[psb_pkg::IRQ_OUT_UNF]    = unf_evt;
        evt[psb_pkg::IRQ_IN_WRITTEN] = h_wr;
        evt[psb_pkg::IRQ_OUT_TAKEN]  = h_rd;
        slave_en_nxt = slave_en_r;
        irq_mask_nxt = irq_mask_r;
        irq_stat_nxt = irq_stat_r;
        aw_got_nxt   = aw_got_r;
        w_got_nxt    = w_got_r;
        awaddr_nxt   = awaddr_r;
        wdata_nxt    = wdata_r;
        wstrb_nxt    = wstrb_r;
        bvalid_nxt   = bvalid_r;
        bresp_nxt    = bresp_r;
        rvalid_nxt   = rvalid_r;
        rdata_nxt    = rdata_r;
        rresp_nxt    = rresp_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (wr_go) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = psb_pkg::RESP_OKAY;
            if (awaddr_r == psb_pkg::ADDR_STATUS) begin
            end else if (awaddr_r == psb_pkg::ADDR_CONTROL) begin
                if (wstrb_r[0]) begin
                    slave_en_nxt = wdata_r[psb_pkg::BIT_SLAVE_EN];
                end
            end else if (awaddr_r == psb_pkg::ADDR_IRQ_STAT) begin
                if (wstrb_r[0]) begin
                    irq_stat_nxt = irq_stat_r & ~wdata_r[3:0];
                end
            end else if (awaddr_r == psb_pkg::ADDR_IRQ_MASK) begin
                if (wstrb_r[0]) begin
                    irq_mask_nxt = wdata_r[3:0];
                end
            end else if (slot_hit(awaddr_r, psb_pkg::ADDR_OUT_BASE)) begin
            end else begin
                bresp_nxt = psb_pkg::RESP_SLVERR;
            end
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        irq_stat_nxt = irq_stat_nxt | evt;
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = psb_pkg::RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            if (s_axi_araddr == psb_pkg::ADDR_STATUS) begin
                rdata_nxt = status_word;
            end else if (s_axi_araddr == psb_pkg::ADDR_CONTROL) begin
                rdata_nxt[psb_pkg::BIT_SLAVE_EN] = slave_en_r;
            end else if (s_axi_araddr == psb_pkg::ADDR_IRQ_STAT) begin
                rdata_nxt[3:0] = irq_stat_r;
            end else if (s_axi_araddr == psb_pkg::ADDR_IRQ_MASK) begin
                rdata_nxt[3:0] = irq_mask_r;
            end else if (slot_hit(s_axi_araddr, psb_pkg::ADDR_IN_BASE)) begin
                rdata_nxt[7:0] = in_data_r[slot_of(s_axi_araddr)];
            end else if (slot_hit(s_axi_araddr, psb_pkg::ADDR_OUT_BASE)) begin
                rdata_nxt[7:0] = out_data_r[slot_of(s_axi_araddr)];
            end else begin
                rresp_nxt = psb_pkg::RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < psb_pkg::NUM_SLOTS; i++) begin
                in_data_r[i]  <= 8'h00;
                out_data_r[i] <= 8'h00;
            end
            host_rd_data_r <= 8'h00;
            slave_en_r     <= 1'b0;
            irq_stat_r     <= 4'h0;
            irq_mask_r     <= 4'h0;
            aw_got_r       <= 1'b0;
            w_got_r        <= 1'b0;
            awaddr_r       <= 8'h00;
            wdata_r        <= 32'h0000_0000;
            wstrb_r        <= 4'h0;
            bvalid_r       <= 1'b0;
            bresp_r        <= 2'h0;
            rvalid_r       <= 1'b0;
            rdata_r        <= 32'h0000_0000;
            rresp_r        <= 2'h0;
        end else begin
            in_data_r      <= in_data_nxt;
            out_data_r     <= out_data_nxt;
            host_rd_data_r <= host_rd_data_nxt;
            slave_en_r     <= slave_en_nxt;
            irq_stat_r     <= irq_stat_nxt;
            irq_mask_r     <= irq_mask_nxt;
            aw_got_r       <= aw_got_nxt;
            w_got_r        <= w_got_nxt;
            awaddr_r       <= awaddr_nxt;
            wdata_r        <= wdata_nxt;
            wstrb_r        <= wstrb_nxt;
            bvalid_r       <= bvalid_nxt;
            bresp_r        <= bresp_nxt;
            rvalid_r       <= rvalid_nxt;
            rdata_r        <= rdata_nxt;
            rresp_r        <= rresp_nxt;
        end
    end

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready  = !w_got_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign host_rd_data  = host_rd_data_r;
    assign irq           = |(irq_stat_r & irq_mask_r);
endmodule

// [sim/parallel_slave_buffer_status_bench.sv]
`timescale 1ns/1ps
module parallel_slave_buffer_status_bench;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, host_wr_slot, host_rd_slot;
    logic [31:0] s_axi_rdata, rd_v;
    logic [7:0]  host_wr_data, host_rd_data, hb;
    logic        host_wr, host_rd, irq;
    logic [1:0]  rsp;
    int          n_errors = 0;
    int          checks_done = 0;
    always #5 aclk = ~aclk;
    psb_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .host_wr(host_wr),
        .host_wr_slot(host_wr_slot), .host_wr_data(host_wr_data), .host_rd(host_rd),
        .host_rd_slot(host_rd_slot), .host_rd_data(host_rd_data), .irq(irq));
    psb_host host (.aclk(aclk), .host_wr(host_wr), .host_wr_slot(host_wr_slot),
        .host_wr_data(host_wr_data), .host_rd(host_rd), .host_rd_slot(host_rd_slot),
        .host_rd_data(host_rd_data));
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        n_errors++;
        $display("unexpected stall at %0t", $time);
        print_verdict();
    endtask
    // a response is taken at the edge where it shows with its ready high
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t, b_t;
        int   n;
        n = 0;
        b_t = 1'b0;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            n++;
            if (n > 40) hang();
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, r_t;
        int   n;
        n = 0;
        r_t = 1'b0;
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        while (!r_t) begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            n++;
            if (n > 40) hang();
        end
    endtask
    task automatic st(input logic [31:0] e);
        axi_rd(psb_pkg::ADDR_STATUS, rd_v, rsp);
        chk(rd_v, e);
    endtask
    task automatic irq_is(input logic e);
        @(negedge aclk);
        chk({31'h0, irq}, {31'h0, e});
        @(posedge aclk);
    endtask
    task automatic t_mode();
        st(32'h0000_0000);
        host.put(2'h0, 8'h11);
        axi_wr(psb_pkg::ADDR_CONTROL, 32'h0000_0001, rsp);
        st(32'h0000_008F);
    endtask
    task automatic t_inputs();
        for (int i = 0; i < 4; i++) begin
            host.put(i[1:0], 8'hA0 + 8'(i));
            st(32'h8F | (((32'h1 << (i + 1)) - 32'h1) << 8)
               | (i == 3 ? 32'h8000 : 32'h0));
        end
        host.put(2'h2, 8'h5A);
        st(32'h0000_CF8F);
        axi_rd(psb_pkg::ADDR_IN_BASE + 8'h08, rd_v, rsp);
        chk(rd_v, 32'h0000_005A);
        st(32'h0000_4B8F);
        axi_wr(psb_pkg::ADDR_STATUS, 32'h0000_4000, rsp);
        st(32'h0000_0B8F);
    endtask
    task automatic t_irq();
        axi_rd(psb_pkg::ADDR_IRQ_STAT, rd_v, rsp);
        chk(rd_v, 32'h0000_0005);
        irq_is(1'b0);
        axi_wr(psb_pkg::ADDR_IRQ_MASK, 32'h0000_0001, rsp);
        irq_is(1'b1);
        axi_wr(psb_pkg::ADDR_IRQ_STAT, 32'h0000_0005, rsp);
        irq_is(1'b0);
    endtask
    task automatic t_outputs();
        axi_wr(psb_pkg::ADDR_OUT_BASE + 8'h04, 32'h0000_003C, rsp);
        st(32'h0000_0B0D);
        host.take(2'h1, hb);
        chk({24'h0, hb}, 32'h0000_003C);
        st(32'h0000_0B8F);
        host.take(2'h0, hb);
        st(32'h0000_0BCF);
        axi_wr(psb_pkg::ADDR_STATUS, 32'h0000_0040, rsp);
        st(32'h0000_0B8F);
    endtask
    task automatic t_unmapped();
        axi_wr(8'hF0, 32'hFFFF_FFFF, rsp);
        chk({30'h0, rsp}, {30'h0, psb_pkg::RESP_SLVERR});
        axi_rd(8'hF0, rd_v, rsp);
        chk({rsp, rd_v[29:0]}, {psb_pkg::RESP_SLVERR, 30'h0});
        st(32'h0000_0B8F);
    endtask
    // ready held low for a few edges: each response must stand until it is taken
    task automatic t_stall();
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        fork
            axi_wr(psb_pkg::ADDR_STATUS, 32'h0000_0000, rsp);
            begin
                repeat (4) @(posedge aclk);
                s_axi_bready <= 1'b1;
            end
        join
        chk({30'h0, rsp}, {30'h0, psb_pkg::RESP_OKAY});
        fork
            axi_rd(psb_pkg::ADDR_IRQ_STAT, rd_v, rsp);
            begin
                repeat (4) @(posedge aclk);
                s_axi_rready <= 1'b1;
            end
        join
        chk(rd_v, 32'h0000_000A);
    endtask
    // reset in mid-run, with three input slots still full from earlier scenarios
    task automatic t_reset();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        st(32'h0000_0000);
        axi_rd(psb_pkg::ADDR_IRQ_STAT, rd_v, rsp);
        chk(rd_v, 32'h0000_0000);
        axi_wr(psb_pkg::ADDR_CONTROL, 32'h0000_0001, rsp);
        st(32'h0000_008F);
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_mode();
        t_inputs();
        t_irq();
        t_outputs();
        t_unmapped();
        t_stall();
        t_reset();
        print_verdict();
    end
endmodule

// [sim/psb_chk.sv]
`timescale 1ns/1ps
module psb_chk (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // axi4-lite response side
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // host and interrupt
    input wire logic        host_rd,
    input wire logic [7:0]  host_rd_data,
    input wire logic        irq
);
    logic stat_rd_r;
    logic stat_rd_nxt;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // remember whether the pending read targets the status word
    always_comb begin
        stat_rd_nxt = stat_rd_r;
        if (s_axi_arvalid && s_axi_arready)
            stat_rd_nxt = (s_axi_araddr == psb_pkg::ADDR_STATUS);
    end
    always_ff @(posedge aclk) begin
        if (!aresetn)
            stat_rd_r <= 1'b0;
        else
            stat_rd_r <= stat_rd_nxt;
    end
    sequence s_stat_ret;
        s_axi_rvalid && stat_rd_r && (s_axi_rresp == psb_pkg::RESP_OKAY);
    endsequence
    property p_all_full;  s_stat_ret |-> s_axi_rdata[15] == &s_axi_rdata[11:8]; endproperty
    property p_all_empty; s_stat_ret |-> s_axi_rdata[7] == &s_axi_rdata[3:0]; endproperty
    property p_gap_zero;
        s_stat_ret |-> s_axi_rdata[13:12] == 2'h0 && s_axi_rdata[5:4] == 2'h0;
    endproperty
    property p_hi_zero;   s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_ar_block;  s_axi_rvalid |-> !s_axi_arready; endproperty
    property p_after_rst;
        $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && host_rd_data == 8'h00;
    endproperty
    property p_byte_hold; !host_rd |=> $stable(host_rd_data); endproperty
    a_all_full:  assert property (p_all_full)  else $error("aggregate full flag wrong");
    a_all_empty: assert property (p_all_empty) else $error("aggregate empty flag wrong");
    a_gap_zero:  assert property (p_gap_zero)  else $error("gap bits not zero");
    a_hi_zero:   assert property (p_hi_zero)   else $error("upper half not zero");
    a_b_hold:    assert property (p_b_hold)    else $error("write response dropped");
    a_r_hold:    assert property (p_r_hold)    else $error("read data dropped");
    a_ar_block:  assert property (p_ar_block)  else $error("read address taken while busy");
    a_after_rst: assert property (p_after_rst) else $error("outputs not idle at reset");
    a_byte_hold: assert property (p_byte_hold) else $error("host byte changed unasked");
endmodule

bind psb_top psb_chk chk (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .host_rd(host_rd), .host_rd_data(host_rd_data), .irq(irq));

// [sim/psb_host.sv]
`timescale 1ns/1ps
module psb_host (
    // clock
    input  wire logic       aclk,
    // strobes toward the port
    output logic            host_wr,
    output logic [1:0]      host_wr_slot,
    output logic [7:0]      host_wr_data,
    output logic            host_rd,
    output logic [1:0]      host_rd_slot,
    // byte returned by the port
    input  wire logic [7:0] host_rd_data
);
    initial begin
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wr_slot = 2'h0;
        host_rd_slot = 2'h0;
        host_wr_data = 8'h00;
    end
    // a well-behaved host only writes non-full slots; the bench decides when it misbehaves
    task automatic put(input logic [1:0] s, input logic [7:0] d);
        host_wr <= 1'b1;
        host_wr_slot <= s;
        host_wr_data <= d;
        @(posedge aclk);
        // released lines show the inverse so a stale byte is never mistaken for a live one
        host_wr <= 1'b0;
        host_wr_slot <= ~s;
        host_wr_data <= ~d;
        @(posedge aclk);
    endtask
    task automatic take(input logic [1:0] s, output logic [7:0] d);
        host_rd <= 1'b1;
        host_rd_slot <= s;
        @(posedge aclk);
        host_rd <= 1'b0;
        host_rd_slot <= ~s;
        @(negedge aclk);
        d = host_rd_data;
        @(posedge aclk);
    endtask
endmodule
